// file: src/tmra_timer.sv
// Sixteen-bit general-purpose timer with control, count and period
// registers, alias addresses and a level interrupt.
// Assumes one 125 MHz clock; extClkPin and gatePin are asynchronous.
`timescale 1ns/10ps
module tmra_timer
  import tmra_pkg::*;
#(
  parameter int ADDR_WIDTH = 16
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Register port
  input wire logic [ADDR_WIDTH-1:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdata,
  // Device state
  input wire logic idleMode,
  // Pins
  input wire logic extClkPin,
  input wire logic gatePin,
  // Interrupt
  output logic timerIrq
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (ADDR_WIDTH < 16 || ADDR_WIDTH > 32) begin : g_bad_addr
    $error("ADDR_WIDTH must lie between 16 and 32");
  end

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic logic slotHit(input logic [ADDR_WIDTH-1:0] a,
                                   input logic [15:0] base);
    slotHit = (a[ADDR_WIDTH-1:4] == (ADDR_WIDTH-4)'(base[15:4]))
              && (a[1:0] == 2'b00);
  endfunction

  function automatic tmra_op_t aliasOp(input logic [ADDR_WIDTH-1:0] a);
    case (a[3:0])
      TMRA_ALIAS_CLR_OFS: aliasOp = TMRA_OP_CLR;
      TMRA_ALIAS_SET_OFS: aliasOp = TMRA_OP_SET;
      TMRA_ALIAS_INV_OFS: aliasOp = TMRA_OP_INV;
      default: aliasOp = TMRA_OP_WRITE;
    endcase
  endfunction

  function automatic logic [15:0] aliasApply(input logic [15:0] old,
                                             input logic [15:0] data,
                                             input tmra_op_t op);
    case (op)
      TMRA_OP_CLR: aliasApply = old & ~data;
      TMRA_OP_SET: aliasApply = old | data;
      TMRA_OP_INV: aliasApply = old ^ data;
      default: aliasApply = data;
    endcase
  endfunction

  function automatic logic exactHit(input logic [ADDR_WIDTH-1:0] a,
                                    input logic [15:0] base);
    exactHit = (a == ADDR_WIDTH'(base));
  endfunction

  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  logic [15:0] control_reg;
  logic [15:0] count_reg;
  logic [15:0] period_reg;
  logic [TMRA_EVT_NUM-1:0] irqStatus_reg;
  logic [TMRA_EVT_NUM-1:0] irqEnable_reg;
  logic [31:0] rdata_reg;
  logic irq_reg;

  logic [2:0] extSync_reg;
  logic [2:0] gateSync_reg;

  // ----------------------------------------------------------------
  // Control field views
  // ----------------------------------------------------------------
  logic timerOn;
  logic stopInIdle;
  logic asyncWriteDisable;
  logic gateAccumulateEnable;
  logic [1:0] prescaleSelect;
  logic externalClockSync;
  logic clockSourceSelect;
  logic asyncMode;
  logic asyncWritePending;

  assign timerOn = control_reg[TMRA_ON_BIT];
  assign stopInIdle = control_reg[TMRA_STOP_IDLE_BIT];
  assign asyncWriteDisable = control_reg[TMRA_WRITE_DIS_BIT];
  assign gateAccumulateEnable = control_reg[TMRA_GATE_EN_BIT];
  assign prescaleSelect = control_reg[TMRA_PRESCALE_HI:TMRA_PRESCALE_LO];
  assign externalClockSync = control_reg[TMRA_EXT_SYNC_BIT];
  assign clockSourceSelect = control_reg[TMRA_CLK_SEL_BIT];
  // Unsynchronised external clock is the asynchronous mode
  assign asyncMode = clockSourceSelect && !externalClockSync;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic hitCtrl;
  logic hitCount;
  logic hitPeriod;
  tmra_op_t busOp;
  logic [15:0] ctrlNew;
  logic [15:0] countNew;
  logic [15:0] periodNew;

  // Control, count and period answer at their base and three aliases
  assign hitCtrl = slotHit(regAddr, TMRA_CTRL_OFS);
  assign hitCount = slotHit(regAddr, TMRA_COUNT_OFS);
  assign hitPeriod = slotHit(regAddr, TMRA_PERIOD_OFS);
  assign busOp = aliasOp(regAddr);
  assign ctrlNew = aliasApply(control_reg, regWdata[15:0], busOp);
  assign countNew = aliasApply(count_reg, regWdata[15:0], busOp);
  assign periodNew = aliasApply(period_reg, regWdata[15:0], busOp);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Bit 0 is the metastable stage; bits 1 and 2 feed logic
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      extSync_reg <= 3'h0;
      gateSync_reg <= 3'h0;
    end else begin
      extSync_reg <= {extSync_reg[1:0], extClkPin};
      gateSync_reg <= {gateSync_reg[1:0], gatePin};
    end
  end

  logic extRise;
  logic gateLevel;
  logic gateFall;

  assign extRise = extSync_reg[1] && !extSync_reg[2];
  assign gateLevel = gateSync_reg[1];
  assign gateFall = !gateSync_reg[1] && gateSync_reg[2];

  // ----------------------------------------------------------------
  // Tick source
  // ----------------------------------------------------------------
  logic running;
  logic srcTick;
  logic tick;
  logic gatedMode;

  // Halted by the enable bit or by idle with stop-in-idle
  assign running = timerOn && !(idleMode && stopInIdle);
  // Gating only applies to the internal clock
  assign gatedMode = !clockSourceSelect && gateAccumulateEnable;

  always_comb begin
    if (!running) begin
      srcTick = 1'b0;
    end else if (clockSourceSelect) begin
      srcTick = extRise;
    end else if (gatedMode) begin
      srcTick = gateLevel;
    end else begin
      srcTick = 1'b1;
    end
  end

  // Prescaler restarts whenever the enable bit is low
  tmra_prescaler u_prescaler (
    .sys_clk(sys_clk),
    .reset(reset),
    .clear(!timerOn),
    .prescaleSelect(prescaleSelect),
    .srcTick(srcTick),
    .tickOut(tick)
  );

  // ----------------------------------------------------------------
  // Count write path
  // ----------------------------------------------------------------
  logic countWriteReq;
  logic countApply;
  logic [15:0] countApplyValue;

  assign countWriteReq = regWrite && hitCount;

  tmra_async_write u_async_write (
    .sys_clk(sys_clk),
    .reset(reset),
    .asyncMode(asyncMode),
    .writeDisable(asyncWriteDisable),
    .extEdge(extRise),
    .writeReq(countWriteReq),
    .writeValue(countNew),
    .pending(asyncWritePending),
    .applyPulse(countApply),
    .applyValue(countApplyValue)
  );

  // ----------------------------------------------------------------
  // Control and period registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      control_reg <= TMRA_CTRL_RST;
    end else if (regWrite && hitCtrl) begin
      control_reg <= ctrlNew & TMRA_CTRL_WMASK;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      period_reg <= TMRA_PERIOD_RST;
    end else if (regWrite && hitPeriod) begin
      period_reg <= periodNew;
    end
  end

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  logic periodMatch;

  assign periodMatch = tick && !countApply && (count_reg == period_reg);

  // A software write overrides the tick of the same cycle
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      count_reg <= TMRA_COUNT_RST;
    end else if (countApply) begin
      count_reg <= countApplyValue;
    end else if (periodMatch) begin
      count_reg <= 16'h0000;
    end else if (tick) begin
      count_reg <= count_reg + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status, clear and enable
  // ----------------------------------------------------------------
  logic [TMRA_EVT_NUM-1:0] events;
  logic [TMRA_EVT_NUM-1:0] clearBits;

  assign events[TMRA_EVT_PERIOD] = periodMatch;
  assign events[TMRA_EVT_GATE] = running && gatedMode && gateFall;
  assign clearBits = (regWrite && exactHit(regAddr, TMRA_IRQ_CLR_OFS))
                     ? regWdata[TMRA_EVT_NUM-1:0] : '0;

  // Set wins over a clear written in the same cycle
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      irqStatus_reg <= '0;
    end else begin
      irqStatus_reg <= (irqStatus_reg & ~clearBits) | events;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      irqEnable_reg <= '0;
    end else if (regWrite && exactHit(regAddr, TMRA_IRQ_EN_OFS)) begin
      irqEnable_reg <= regWdata[TMRA_EVT_NUM-1:0];
    end
  end

  // Lags the status bit by one cycle so the output is a flop
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(irqStatus_reg & irqEnable_reg);
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic [15:0] ctrlView;
  logic [31:0] readMux;

  // Pending flag forced low outside asynchronous mode
  always_comb begin
    ctrlView = control_reg;
    ctrlView[TMRA_WRITE_PEND_BIT] = asyncWritePending;
  end

  // Aliases read back the register itself; unmapped reads give zero
  always_comb begin
    readMux = 32'h0000_0000;
    if (hitCtrl) begin
      readMux = {16'h0000, ctrlView};
    end else if (hitCount) begin
      readMux = {16'h0000, count_reg};
    end else if (hitPeriod) begin
      readMux = {16'h0000, period_reg};
    end else if (exactHit(regAddr, TMRA_IRQ_STAT_OFS)) begin
      readMux = {{(32 - TMRA_EVT_NUM){1'b0}}, irqStatus_reg};
    end else if (exactHit(regAddr, TMRA_IRQ_EN_OFS)) begin
      readMux = {{(32 - TMRA_EVT_NUM){1'b0}}, irqEnable_reg};
    end
  end

  // Data stand for exactly the cycle after the strobe
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rdata_reg <= 32'h0000_0000;
    end else if (regRead) begin
      rdata_reg <= readMux;
    end else begin
      rdata_reg <= 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign regRdata = rdata_reg;
  assign timerIrq = irq_reg;

endmodule

// file: src/tmra_pkg.sv
// Constants shared by the sixteen-bit timer block.
// Assumes a 32-bit register port with byte addresses.
package tmra_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [15:0] TMRA_CTRL_OFS = 16'h0600;
  localparam logic [15:0] TMRA_COUNT_OFS = 16'h0610;
  localparam logic [15:0] TMRA_PERIOD_OFS = 16'h0620;
  localparam logic [15:0] TMRA_IRQ_STAT_OFS = 16'h0630;
  localparam logic [15:0] TMRA_IRQ_CLR_OFS = 16'h0640;
  localparam logic [15:0] TMRA_IRQ_EN_OFS = 16'h0650;

  // Alias offsets within a register's 16-byte slot
  localparam logic [3:0] TMRA_ALIAS_CLR_OFS = 4'h4;
  localparam logic [3:0] TMRA_ALIAS_SET_OFS = 4'h8;
  localparam logic [3:0] TMRA_ALIAS_INV_OFS = 4'hC;

  // ----------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------
  localparam int TMRA_ON_BIT = 15;
  localparam int TMRA_STOP_IDLE_BIT = 13;
  localparam int TMRA_WRITE_DIS_BIT = 12;
  localparam int TMRA_WRITE_PEND_BIT = 11;
  localparam int TMRA_GATE_EN_BIT = 7;
  localparam int TMRA_PRESCALE_HI = 5;
  localparam int TMRA_PRESCALE_LO = 4;
  localparam int TMRA_EXT_SYNC_BIT = 2;
  localparam int TMRA_CLK_SEL_BIT = 1;
  localparam logic [15:0] TMRA_CTRL_WMASK = 16'hB0B6;

  // ----------------------------------------------------------------
  // Reset values and event bits
  // ----------------------------------------------------------------
  localparam logic [15:0] TMRA_CTRL_RST = 16'h0000;
  localparam logic [15:0] TMRA_COUNT_RST = 16'h0000;
  localparam logic [15:0] TMRA_PERIOD_RST = 16'hFFFF;
  localparam int TMRA_EVT_PERIOD = 0;
  localparam int TMRA_EVT_GATE = 1;
  localparam int TMRA_EVT_NUM = 2;

  // ----------------------------------------------------------------
  // Prescale divisors (minus one), by select code
  // ----------------------------------------------------------------
  localparam logic [7:0] TMRA_DIV1_M1 = 8'h00;
  localparam logic [7:0] TMRA_DIV8_M1 = 8'h07;
  localparam logic [7:0] TMRA_DIV64_M1 = 8'h3F;
  localparam logic [7:0] TMRA_DIV256_M1 = 8'hFF;

  typedef enum logic [1:0] {
    TMRA_OP_WRITE = 2'b00,
    TMRA_OP_CLR = 2'b01,
    TMRA_OP_SET = 2'b10,
    TMRA_OP_INV = 2'b11
  } tmra_op_t;

  typedef enum logic [0:0] {
    TMRA_WR_IDLE = 1'b0,
    TMRA_WR_PENDING = 1'b1
  } tmra_wr_state_t;

endpackage

// file: src/tmra_prescaler.sv
// Input prescaler: passes one of every 1, 8, 64 or 256 source ticks.
// Assumes source ticks are one-cycle pulses on sys_clk.
`timescale 1ns/10ps
module tmra_prescaler
  import tmra_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Control
  input wire logic clear,
  input wire logic [1:0] prescaleSelect,
  // Ticks
  input wire logic srcTick,
  output logic tickOut
);

  logic [7:0] divCount_reg;
  logic [7:0] divLimit;

  always_comb begin
    case (prescaleSelect)
      2'b11: divLimit = TMRA_DIV256_M1;
      2'b10: divLimit = TMRA_DIV64_M1;
      2'b01: divLimit = TMRA_DIV8_M1;
      default: divLimit = TMRA_DIV1_M1;
    endcase
  end

  // Compare with >= so a smaller divisor chosen mid-count still wraps
  assign tickOut = srcTick && (divCount_reg >= divLimit);

  always_ff @(posedge sys_clk) begin
    if (reset || clear) begin
      divCount_reg <= 8'h00;
    end else if (tickOut) begin
      divCount_reg <= 8'h00;
    end else if (srcTick) begin
      divCount_reg <= divCount_reg + 8'h01;
    end
  end

endmodule

// file: src/tmra_async_write.sv
// Holds a count-register write until the next external clock edge
// when the timer runs on an unsynchronised external clock.
// Assumes extEdge is a one-cycle pulse already synchronised.
`timescale 1ns/10ps
module tmra_async_write
  import tmra_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Mode
  input wire logic asyncMode,
  input wire logic writeDisable,
  input wire logic extEdge,
  // Write request
  input wire logic writeReq,
  input wire logic [15:0] writeValue,
  // Result
  output logic pending,
  output logic applyPulse,
  output logic [15:0] applyValue
);

  tmra_wr_state_t state_reg;
  logic [15:0] held_reg;
  logic accept;

  assign pending = asyncMode && (state_reg == TMRA_WR_PENDING);
  // A protected pending write locks out newer ones
  assign accept = writeReq && !(pending && writeDisable);
  // Sync mode applies at once; async waits for the external clock edge
  assign applyPulse = asyncMode ? (state_reg == TMRA_WR_PENDING && extEdge)
                                : (writeReq || state_reg == TMRA_WR_PENDING);
  assign applyValue = (!asyncMode && writeReq) ? writeValue : held_reg;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_reg <= TMRA_WR_IDLE;
      held_reg <= 16'h0000;
    end else begin
      case (state_reg)
        TMRA_WR_IDLE: begin
          if (asyncMode && accept) begin
            state_reg <= TMRA_WR_PENDING;
            held_reg <= writeValue;
          end
        end
        TMRA_WR_PENDING: begin
          // A new write in the completing cycle stays pending
          if (asyncMode && accept) begin
            held_reg <= writeValue;
          end else if (applyPulse) begin
            state_reg <= TMRA_WR_IDLE;
          end
        end
        default: state_reg <= TMRA_WR_IDLE;
      endcase
    end
  end

endmodule

// file: tb/tmra_timer_props.sv
// Concurrent checks on the sixteen-bit timer, watching top-level ports only.
// Assumes software writes the period through its base address only.
`timescale 1ns/10ps
module tmra_timer_props
  import tmra_pkg::*;
#(
  parameter int ADDR_WIDTH = 16
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Register port
  input wire logic [ADDR_WIDTH-1:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [31:0] regRdata,
  // Device state and pins
  input wire logic idleMode,
  input wire logic extClkPin,
  input wire logic gatePin,
  input wire logic timerIrq
);
  logic [15:0] periodShadow_reg;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);

  // Shadow of the period, so that any count read can be bounded
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      periodShadow_reg <= 16'hFFFF;
    end else if (regWrite && regAddr == TMRA_PERIOD_OFS) begin
      periodShadow_reg <= regWdata[15:0];
    end
  end

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  rdata_idle_a: assert property (!regRead |=> regRdata == 32'h0)
    else $error("read data outside read slot");
  upper_zero_a: assert property (regRead |=> regRdata[31:16] == 16'h0)
    else $error("upper read bits not zero");
  unmapped_read_a: assert property (
    regRead && regAddr >= 16'h0660 || regRead && regAddr == TMRA_IRQ_CLR_OFS
    |=> regRdata == 32'h0)
    else $error("hole or clear register read not zero");
  ctrl_back_a: assert property (
    regWrite && regAddr == TMRA_CTRL_OFS ##1 !regWrite ##1 regRead && regAddr == TMRA_CTRL_OFS
    |=> (regRdata[15:0] & TMRA_CTRL_WMASK) == ($past(regWdata[15:0], 3) & TMRA_CTRL_WMASK))
    else $error("control readback differs from write");
  set_alias_a: assert property (
    regWrite && regAddr == TMRA_CTRL_OFS + 16'h8 ##1 !regWrite
    ##1 regRead && regAddr == TMRA_CTRL_OFS
    |=> (regRdata[15:0] & $past(regWdata[15:0], 3) & TMRA_CTRL_WMASK)
    == ($past(regWdata[15:0], 3) & TMRA_CTRL_WMASK))
    else $error("set alias left a bit low");
  clr_alias_a: assert property (
    regWrite && regAddr == TMRA_CTRL_OFS + 16'h4 ##1 !regWrite
    ##1 regRead && regAddr == TMRA_CTRL_OFS
    |=> (regRdata[15:0] & $past(regWdata[15:0], 3) & TMRA_CTRL_WMASK) == 16'h0)
    else $error("clear alias left a bit high");
  sync_pend_a: assert property (
    regRead && regAddr == TMRA_CTRL_OFS
    |=> (regRdata[1] && !regRdata[2]) || !regRdata[11])
    else $error("pending flag set in synchronous mode");

  // ----------------------------------------------------------------
  // Count and interrupt
  // ----------------------------------------------------------------
  count_bound_a: assert property (
    regRead && regAddr == TMRA_COUNT_OFS |=> regRdata[15:0] <= periodShadow_reg)
    else $error("count read above period");
  irq_mask_a: assert property (
    regWrite && regAddr == TMRA_IRQ_EN_OFS && regWdata[1:0] == 2'b00 |=> ##1 !timerIrq)
    else $error("interrupt high after masking");

  cover property (regRead && regAddr == TMRA_COUNT_OFS);
  cover property ($rose(timerIrq));
  cover property (regWrite && regAddr == TMRA_CTRL_OFS + 16'hC);
endmodule

bind tmra_timer tmra_timer_props #(.ADDR_WIDTH(ADDR_WIDTH)) u_props (
  .sys_clk(sys_clk), .reset(reset), .regAddr(regAddr), .regWdata(regWdata),
  .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .idleMode(idleMode),
  .extClkPin(extClkPin), .gatePin(gatePin), .timerIrq(timerIrq));

// file: tb/tmra_timer_tb.sv
// Self-checking bench for the sixteen-bit timer.
// Drives the register port and pins itself; the checker is bound separately.
`timescale 1ns/10ps
`define CHK(nm, ex, gt) begin testsRun++; if ((gt) !== (ex)) begin nErrors++; \
  $display("BAD %s exp %h got %h", nm, ex, gt); end end
module tmra_timer_tb
  import tmra_pkg::*;
;
  logic sys_clk, reset, regWrite, regRead, idleMode, extClkPin, gatePin, timerIrq;
  logic [15:0] regAddr;
  logic [31:0] regWdata, regRdata, rv, d32;
  logic [15:0] ctl, cnt;
  int nErrors, testsRun, seed;

  tmra_timer #(.ADDR_WIDTH(16)) u_dut (.sys_clk(sys_clk), .reset(reset),
    .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regRdata(regRdata), .idleMode(idleMode), .extClkPin(extClkPin),
    .gatePin(gatePin), .timerIrq(timerIrq));

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // ----------------------------------------------------------------
  // Bus tasks and expectations
  // ----------------------------------------------------------------
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge sys_clk);
    regWrite <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRead <= 1'b0;
    // Data stand in this cycle only; take them at the edge that closes it
    @(posedge sys_clk);
    d = regRdata;
  endtask

  task automatic chk_rd(input logic [15:0] a, input logic [15:0] ex, input string nm);
    rd(a, rv);
    `CHK(nm, {16'h0, ex}, rv)
  endtask

  task automatic chk_rng(input logic [15:0] q, input int lo, input int hi, input string nm);
    `CHK(nm, 1'b1, (q >= lo) && (q <= hi))
  endtask

  function automatic int divOf(input int k);
    return (k == 0) ? 1 : (k == 1) ? 8 : (k == 2) ? 64 : 256;
  endfunction

  function automatic logic [15:0] aliasExp(input logic [15:0] o, input logic [15:0] d,
                                           input int op);
    case (op)
      0: return d & TMRA_CTRL_WMASK;
      1: return o & ~d;
      2: return o | (d & TMRA_CTRL_WMASK);
      default: return o ^ (d & TMRA_CTRL_WMASK);
    endcase
  endfunction

  // Runs from count zero for about n cycles, stops and reads the count
  task automatic run(input logic [15:0] c, input int n, output logic [15:0] q);
    wr(TMRA_CTRL_OFS, 32'h0);
    wr(TMRA_COUNT_OFS, 32'h0);
    wr(TMRA_CTRL_OFS, {16'h0, c});
    repeat (n) @(posedge sys_clk);
    wr(TMRA_CTRL_OFS, 32'h0);
    rd(TMRA_COUNT_OFS, rv);
    q = rv[15:0];
  endtask

  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      extClkPin <= 1'b1;
      repeat (4) @(posedge sys_clk);
      extClkPin <= 1'b0;
      repeat (3) @(posedge sys_clk);
    end
  endtask

  task automatic finalReport();
    if (nErrors == 0 && testsRun > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Whole run is under two thousand cycles; this is ample margin
  initial begin
    #400000;
    nErrors++;
    finalReport();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {reset, regWrite, regRead, idleMode, extClkPin, gatePin} = 6'b100000;
    regAddr = 16'h0;
    regWdata = 32'h0;
    seed = 64;
    nErrors = 0;
    testsRun = 0;
    repeat (5) @(posedge sys_clk);
    reset <= 1'b0;
    chk_rd(TMRA_CTRL_OFS, 16'h0000, "ctrl");
    chk_rd(TMRA_COUNT_OFS, 16'h0000, "count");
    chk_rd(TMRA_PERIOD_OFS, 16'hFFFF, "period");
    chk_rd(TMRA_IRQ_STAT_OFS, 16'h0, "stat");
    chk_rd(TMRA_IRQ_CLR_OFS, 16'h0, "clr");
    chk_rd(16'h0660, 16'h0, "hole");
    // Enable kept low so the control value is all that moves
    ctl = 16'h0;
    for (int i = 0; i < 16; i++) begin
      d32 = $random(seed);
      d32[15] = 1'b0;
      wr(TMRA_CTRL_OFS | 16'(i % 4 * 4), d32);
      ctl = aliasExp(ctl, d32[15:0], i % 4);
      chk_rd(TMRA_CTRL_OFS, ctl, "alias");
    end
    for (int k = 0; k < 4; k++) begin
      int dv;
      dv = divOf(k);
      run(16'h8000 | 16'(k * 16), 3 * dv + dv / 2, cnt);
      chk_rng(cnt, 2, (3 * dv + dv / 2 + 2) / dv, "prescale");
    end
    run(16'h0000, 30, cnt);
    chk_rng(cnt, 0, 0, "off");
    run(16'h8080, 30, cnt);
    chk_rng(cnt, 0, 0, "gate low");
    gatePin <= 1'b1;
    run(16'h8080, 30, cnt);
    chk_rng(cnt, 27, 32, "gate high");
    // Gate falls while gated counting runs: status bit 1 must latch
    wr(TMRA_CTRL_OFS, 32'h8080);
    gatePin <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk_rd(TMRA_IRQ_STAT_OFS, 16'h2, "gate fall");
    fork
      run(16'h8086, 70, cnt);
      begin
        repeat (10) @(posedge sys_clk);
        pulses(5);
      end
    join
    chk_rng(cnt, 5, 5, "ext edges");
    idleMode <= 1'b1;
    run(16'hA000, 30, cnt);
    chk_rng(cnt, 0, 0, "idle stop");
    run(16'h8000, 30, cnt);
    chk_rng(cnt, 29, 32, "idle run");
    idleMode <= 1'b0;
    wr(TMRA_IRQ_CLR_OFS, 32'h3);
    wr(TMRA_PERIOD_OFS, 32'h3);
    wr(TMRA_IRQ_EN_OFS, 32'h1);
    run(16'h8000, 20, cnt);
    chk_rng(cnt, 0, 3, "wrap");
    chk_rd(TMRA_IRQ_STAT_OFS, 16'h1, "stat");
    #1 `CHK("irq", 1'b1, timerIrq)
    wr(TMRA_IRQ_EN_OFS, 32'h0);
    @(posedge sys_clk);
    #1 `CHK("irq masked", 1'b0, timerIrq)
    wr(TMRA_IRQ_EN_OFS, 32'h1);
    @(posedge sys_clk);
    #1 `CHK("irq unmasked", 1'b1, timerIrq)
    wr(TMRA_IRQ_CLR_OFS, 32'h1);
    @(posedge sys_clk);
    #1 `CHK("irq cleared", 1'b0, timerIrq)
    chk_rd(TMRA_IRQ_STAT_OFS, 16'h0, "stat clr");
    wr(TMRA_PERIOD_OFS, 32'hFFFF);
    wr(TMRA_COUNT_OFS, 32'h0);
    wr(TMRA_CTRL_OFS, 32'h1002);
    d32 = $random(seed);
    wr(TMRA_COUNT_OFS, d32);
    wr(TMRA_COUNT_OFS, ~d32);
    chk_rd(TMRA_CTRL_OFS, 16'h1802, "pending");
    chk_rd(TMRA_COUNT_OFS, 16'h0, "held");
    pulses(1);
    chk_rd(TMRA_COUNT_OFS, d32[15:0], "kept first");
    chk_rd(TMRA_CTRL_OFS, 16'h1002, "done");
    wr(TMRA_CTRL_OFS, 32'h0002);
    wr(TMRA_COUNT_OFS, ~d32);
    wr(TMRA_COUNT_OFS, d32 ^ 32'h00FF);
    pulses(1);
    chk_rd(TMRA_COUNT_OFS, d32[15:0] ^ 16'h00FF, "replace");
    wr(TMRA_CTRL_OFS, 32'h0006);
    wr(TMRA_COUNT_OFS, d32);
    chk_rd(TMRA_CTRL_OFS, 16'h0006, "sync flag");
    chk_rd(TMRA_COUNT_OFS, d32[15:0], "sync write");
    finalReport();
  end
endmodule
